// ---- bench/dlm_config_checker.sv ----
// Port checker of the link mode configuration bank.
// Assumes it is bound onto dlm_config_bank.
`timescale 1ns/1ps
module dlm_config_checker
	import dlm_pkg::*;
(
	input wire logic      core_clk,     // System clock
	input wire logic      rst,          // Async reset, high
	input wire logic      sen_n,        // Frame enable, low
	input wire dlm_main_s main_cfg,     // Active main fields
	input wire dlm_link_s link_cfg,     // Link fields
	input wire logic      cfg_supported // Active option flag
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	dlm_main_s  m_q;
	dlm_link_s  l_q;
	logic       ok;
	logic       dec;
	logic [3:0] resp;
	logic [2:0] filt;
	logic [2:0] fmt;
	logic       lane;
	logic [1:0] pll;
	logic [7:0] oa;
	logic [7:0] ob;
	always_ff @(posedge core_clk) begin
		m_q <= main_cfg;
		l_q <= link_cfg;
	end
	assign ok = cfg_supported && main_cfg == m_q && link_cfg == l_q;
	assign dec = main_cfg.decimation_path_enable;
	assign resp = main_cfg.filter_response_code;
	assign {filt, fmt, lane, pll, oa, ob} = link_cfg;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	main_in_frame_a: assert property (main_cfg != m_q |-> !sen_n)
		else $error("main settings moved outside a frame");
	main_settle_a: assert property (main_cfg != m_q |=> (main_cfg == m_q) [*3])
		else $error("main settings moved twice");
	link_in_frame_a: assert property (link_cfg != l_q |-> !sen_n)
		else $error("link settings moved outside a frame");
	enable_pair_a: assert property (ok |-> main_cfg.filter_enable == dec
		&& main_cfg.word_order_enable_first == dec && main_cfg.word_order_enable_second == dec)
		else $error("enables disagree in a listed option");
	nodec_zero_a: assert property (ok && !dec |-> filt == 3'h0 && resp == 4'h0
		&& oa == 8'h00 && ob == 8'h00) else $error("nonzero fields without decimation");
	dec_order_a: assert property (ok && dec |-> oa == 8'h0A && ob == 8'h0A)
		else $error("word order wrong while decimating");
	iq_resp_a: assert property (ok && filt == 3'h7 |-> resp == 4'h3)
		else $error("complex filter with wrong response");
	x2_resp_a: assert property (ok && filt == 3'h6 |-> resp inside {4'h2, 4'h6})
		else $error("2x filter with wrong response");
	real_resp_a: assert property (ok && filt == 3'h4 |-> resp[1:0] == 2'h0
		&& lane == (fmt == 3'h2)) else $error("real 4x option inconsistent");
	pll_fmt_a: assert property (ok |-> (pll == 2'h2) == (fmt != 3'h1))
		else $error("serializer code does not suit format");
endmodule

bind dlm_config_bank dlm_config_checker i_chk (.core_clk(core_clk), .rst(rst), .sen_n(sen_n),
	.main_cfg(main_cfg), .link_cfg(link_cfg), .cfg_supported(cfg_supported));

// ---- bench/dlm_host_model.sv ----
// Host model that shifts 24-bit frames into the serial register port.
// Assumes core_clk at 8 ns; each sclk level lasts three core_clk cycles.
`timescale 1ns/1ps
module dlm_host_model (
	input  wire logic core_clk, // System clock
	input  wire logic sdout,    // Read data
	output logic      sclk,     // Serial clock
	output logic      sdin,     // Serial data
	output logic      sen_n     // Frame enable, low
);
	// ------------------------------------------------------------
	// Frame driver
	// ------------------------------------------------------------
	initial begin
		sclk = 1'b0;
		sdin = 1'b0;
		sen_n = 1'b1;
	end
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Fewer than 24 bits gives a cut-off frame
	task automatic xfer(input logic [23:0] f, input int n, output logic [7:0] rd);
		rd = 8'h00;
		sen_n = 1'b0;
		for (int i = 23; i > 23 - n; i--) begin
			sdin = f[i];
			step(3);
			if (i < 8) rd[i] = sdout;
			sclk = 1'b1;
			step(3);
			sclk = 1'b0;
		end
		step(6);
		sen_n = 1'b1;
		sdin = ~sdin;
		step(3);
	endtask
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench of the link mode configuration bank.
// Assumes the host model on the serial port and the bound checker.
`timescale 1ns/1ps
`include "dlm_map.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top
	import dlm_pkg::*;
;
	// ------------------------------------------------------------
	// Harness
	// ------------------------------------------------------------
	logic      core_clk;
	logic      rst;
	wire logic sclk;
	wire logic sdin;
	wire logic sen_n;
	logic      sdout;
	dlm_main_s main_cfg;
	dlm_link_s link_cfg;
	logic      cfg_supported;
	logic      stage_supported;
	logic [7:0] rd;
	int        mismatches = 0;
	int        check_count = 0;
	localparam logic       T_DEC [9] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1};
	localparam logic [3:0] T_RSP [9] = '{4'h0, 4'h0, 4'h0, 4'h3, 4'h2, 4'h6, 4'h4, 4'h3, 4'hC};
	localparam logic [2:0] T_FIL [9] = '{3'h0, 3'h0, 3'h0, 3'h7, 3'h6, 3'h6, 3'h4, 3'h7, 3'h4};
	localparam logic [2:0] T_FMT [9] = '{3'h4, 3'h2, 3'h1, 3'h1, 3'h1, 3'h2, 3'h1, 3'h2, 3'h2};
	localparam logic [1:0] T_PLL [9] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h2, 2'h2};
	dlm_config_bank i_dut (.core_clk(core_clk), .rst(rst), .sclk(sclk), .sdin(sdin),
		.sen_n(sen_n), .sdout(sdout), .main_cfg(main_cfg), .link_cfg(link_cfg),
		.cfg_supported(cfg_supported), .stage_supported(stage_supported));
	dlm_host_model i_host (.core_clk(core_clk), .sdout(sdout), .sclk(sclk), .sdin(sdin),
		.sen_n(sen_n));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic wr(input logic [2:0] pg, input logic [11:0] a, input logic [7:0] d);
		i_host.xfer({1'b0, pg, a, d}, 24, rd);
	endtask
	task automatic rdreg(input logic [2:0] pg, input logic [11:0] a);
		i_host.xfer({1'b1, pg, a, 8'h00}, 24, rd);
	endtask
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	task automatic test_reset;
		`CHK("main_cfg", 8'h00, main_cfg)
		`CHK("link_cfg", dlm_link_s'({3'h0, 3'h1, 1'h0, 2'h0, 16'h0000}), link_cfg)
		`CHK("cfg_supported", 1'h1, cfg_supported)
		$display("test_reset done");
	endtask
	task automatic test_options;
		logic       d;
		logic [3:0] r;
		logic [7:0] o;
		dlm_main_s  prev;
		for (int k = 0; k < 9; k++) begin
			d = T_DEC[k];
			r = T_RSP[k];
			o = d ? 8'h0A : 8'h00;
			prev = main_cfg;
			wr(`DLM_PG_MAIN, `DLM_A_FILTER, {2'h0, r[3], d, 1'h0, r[2:0]});
			wr(`DLM_PG_MAIN, `DLM_A_DECIM, {4'h0, d, 3'h0});
			wr(`DLM_PG_MAIN, `DLM_A_ORDER_EN1, {d, 7'h00});
			wr(`DLM_PG_MAIN, `DLM_A_ORDER_EN2, {4'h0, d, 3'h0});
			wr(`DLM_PG_LINK_DIG, `DLM_A_LINK_FMT, {2'h0, T_FIL[k], T_FMT[k]});
			wr(`DLM_PG_LINK_DIG, `DLM_A_SHARING, {3'h0, k == 8, 4'h0});
			wr(`DLM_PG_LINK_ANA, `DLM_A_PLL, {6'h00, T_PLL[k]});
			wr(`DLM_PG_LINK_DIG, `DLM_A_ORDER_A, o);
			wr(`DLM_PG_LINK_DIG, `DLM_A_ORDER_B, o);
			`CHK("main_cfg held", prev, main_cfg)
			`CHK("stage_supported", 1'h1, stage_supported)
			rdreg(`DLM_PG_MAIN, `DLM_A_DECIM);
			`CHK("decim readback", {4'h0, d, 3'h0}, rd)
			rdreg(`DLM_PG_MAIN, `DLM_A_FILTER);
			`CHK("filter readback", {2'h0, r[3], d, 1'h0, r[2:0]}, rd)
			rdreg(`DLM_PG_LINK_ANA, `DLM_A_PLL);
			`CHK("pll readback", {6'h00, T_PLL[k]}, rd)
			rdreg(`DLM_PG_LINK_DIG, `DLM_A_LINK_FMT);
			`CHK("link readback", {2'h0, T_FIL[k], T_FMT[k]}, rd)
			wr(`DLM_PG_MAIN, `DLM_A_RESTART, 8'h01);
			`CHK("main_cfg", dlm_main_s'{d, d, r, d, d}, main_cfg)
			`CHK("link_cfg", dlm_link_s'{T_FIL[k], T_FMT[k], k == 8, T_PLL[k], o, o}, link_cfg)
			`CHK("cfg_supported", 1'h1, cfg_supported)
			rdreg(`DLM_PG_MAIN, `DLM_A_RESTART);
			`CHK("restart readback", 8'h00, rd)
		end
		$display("test_options done");
	endtask
	task automatic test_refuse;
		i_host.xfer({1'b0, `DLM_PG_LINK_DIG, `DLM_A_ORDER_A, 8'hFF}, 20, rd);
		`CHK("short frame", 8'h0A, link_cfg.chan_a_word_order)
		wr(`DLM_PG_LINK_DIG, `DLM_A_LINK_FMT, {2'h0, 3'h7, 3'h2});
		`CHK("unlisted option", 1'h0, cfg_supported)
		`CHK("fields kept", 8'h0A, link_cfg.chan_b_word_order)
		$display("test_refuse done");
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		repeat (10) @(posedge core_clk);
		#1;
		rst = 1'b0;
		test_reset;
		test_options;
		test_refuse;
		close_out;
	end
	initial begin
		#320000;
		mismatches++;
		close_out;
	end
endmodule

// ---- include/dlm_map.svh ----
// Address map, field positions and reset values of the link mode configuration bank.
// Assumes a host that writes 24-bit serial frames: rw, page, address, data.
`ifndef DLM_MAP_SVH
`define DLM_MAP_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define DLM_FRAME_BITS    24
`define DLM_HDR_BITS      16
`define DLM_CNT_W         5

// ----------------------------------------------------------------
// Page codes
// ----------------------------------------------------------------
`define DLM_PG_MAIN       3'h1
`define DLM_PG_LINK_DIG   3'h2
`define DLM_PG_LINK_ANA   3'h3

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DLM_A_RESTART     12'h000
`define DLM_A_FILTER      12'h041
`define DLM_A_DECIM       12'h04D
`define DLM_A_ORDER_EN1   12'h052
`define DLM_A_ORDER_EN2   12'h072
`define DLM_A_LINK_FMT    12'h001
`define DLM_A_SHARING     12'h016
`define DLM_A_ORDER_A     12'h031
`define DLM_A_ORDER_B     12'h032
`define DLM_A_PLL         12'h016

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DLM_B_RESTART     0
`define DLM_B_DEC_EN      3
`define DLM_B_FIL_EN      4
`define DLM_B_RESP_MSB    5
`define DLM_F_RESP_LO     2:0
`define DLM_B_ORDER_EN1   7
`define DLM_B_ORDER_EN2   3
`define DLM_B_SHARING     4
`define DLM_F_LINK_FILT   5:3
`define DLM_F_LINK_FMT    2:0
`define DLM_F_PLL         1:0

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define DLM_FMT_RST       3'h1
`define DLM_PLL_RST       2'h0
`define DLM_FMT_A         3'h1
`define DLM_FMT_B         3'h2
`define DLM_FMT_C         3'h4
`define DLM_PLL_A         2'h0
`define DLM_PLL_B         2'h2
`define DLM_FILT_NONE     3'h0
`define DLM_FILT_IQ4      3'h7
`define DLM_FILT_X2       3'h6
`define DLM_FILT_R4       3'h4
`define DLM_RESP_IQ4      4'h3
`define DLM_RESP_LPF      4'h2
`define DLM_RESP_HPF      4'h6
`define DLM_ORDER_DEC     8'h0A

`endif

// ---- include/dlm_pkg.sv ----
// Types shared by the link mode configuration bank and its serial port.
// Assumes dlm_map.svh supplies the numeric constants.
package dlm_pkg;

	typedef struct packed {
		logic       decimation_path_enable;
		logic       filter_enable;
		logic [3:0] filter_response_code;
		logic       word_order_enable_first;
		logic       word_order_enable_second;
	} dlm_main_s;

	typedef struct packed {
		logic [2:0] link_filter_code;
		logic [2:0] link_format_code;
		logic       lane_sharing;
		logic [1:0] serializer_pll_code;
		logic [7:0] chan_a_word_order;
		logic [7:0] chan_b_word_order;
	} dlm_link_s;

	typedef struct packed {
		logic        wr;
		logic [2:0]  page;
		logic [11:0] addr;
		logic [7:0]  data;
	} dlm_req_s;

endpackage

// ---- logic/dlm_config_bank.sv ----
// Link mode configuration bank: staged main page, link page, restart strobe.
// Assumes a host on the serial register port; outputs feed the filter and link logic.
`timescale 1ns/1ps
`include "dlm_map.svh"

module dlm_config_bank
	import dlm_pkg::*;
(
	input  wire logic core_clk,       // System clock
	input  wire logic rst,            // Async reset, high
	input  wire logic sclk,           // Serial clock
	input  wire logic sdin,           // Serial data in
	input  wire logic sen_n,          // Frame enable, low
	output logic      sdout,          // Serial data out
	output dlm_main_s main_cfg,       // Active main page settings
	output dlm_link_s link_cfg,       // Link page settings
	output logic      cfg_supported,  // Active setting is a listed option
	output logic      stage_supported // Staged setting is a listed option
);

	// ----------------------------------------------------------------
	// Option check
	// ----------------------------------------------------------------
	function automatic logic dlm_pair_ok(input dlm_link_s l, input logic fmt_c_ok);
		dlm_pair_ok = (l.link_format_code == `DLM_FMT_A && l.serializer_pll_code == `DLM_PLL_A)
			|| (l.link_format_code == `DLM_FMT_B && l.serializer_pll_code == `DLM_PLL_B)
			|| (fmt_c_ok && l.link_format_code == `DLM_FMT_C
				&& l.serializer_pll_code == `DLM_PLL_B);
	endfunction

	function automatic logic dlm_option_ok(input dlm_main_s m, input dlm_link_s l);
		logic dec;
		logic ord;
		dec = m.decimation_path_enable && m.filter_enable;
		ord = l.chan_a_word_order == `DLM_ORDER_DEC && l.chan_b_word_order == `DLM_ORDER_DEC
			&& m.word_order_enable_first && m.word_order_enable_second;
		dlm_option_ok = 1'b0;
		if (!m.decimation_path_enable && !m.filter_enable) begin
			dlm_option_ok = m.filter_response_code == 4'h0
				&& l.link_filter_code == `DLM_FILT_NONE && !l.lane_sharing
				&& l.chan_a_word_order == 8'h00 && l.chan_b_word_order == 8'h00
				&& !m.word_order_enable_first && !m.word_order_enable_second
				&& dlm_pair_ok(l, 1'b1);
		end else if (dec && ord) begin
			case (l.link_filter_code)
				`DLM_FILT_IQ4: begin
					dlm_option_ok = m.filter_response_code == `DLM_RESP_IQ4
						&& !l.lane_sharing && dlm_pair_ok(l, 1'b0);
				end
				`DLM_FILT_X2: begin
					dlm_option_ok = (m.filter_response_code == `DLM_RESP_LPF
						|| m.filter_response_code == `DLM_RESP_HPF)
						&& !l.lane_sharing && dlm_pair_ok(l, 1'b0);
				end
				`DLM_FILT_R4: begin
					dlm_option_ok = m.filter_response_code[1:0] == 2'h0
						&& ((l.link_format_code == `DLM_FMT_A
							&& l.serializer_pll_code == `DLM_PLL_A && !l.lane_sharing)
						|| (l.link_format_code == `DLM_FMT_B
							&& l.serializer_pll_code == `DLM_PLL_B && l.lane_sharing));
				end
				default: begin
					dlm_option_ok = 1'b0;
				end
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Serial port
	// ----------------------------------------------------------------
	dlm_req_s   req;
	logic [7:0] rd_data;

	dlm_serial_port u_port (
		.core_clk (core_clk),
		.rst      (rst),
		.sclk     (sclk),
		.sdin     (sdin),
		.sen_n    (sen_n),
		.rd_data  (rd_data),
		.req      (req),
		.sdout    (sdout)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		dlm_main_s stage;
		dlm_main_s act;
		dlm_link_s link;
		logic      act_ok;
		logic      stage_ok;
	} dlm_bank_s;

	dlm_bank_s st_reg;
	dlm_bank_s st_next;

	localparam dlm_link_s LINK_RST = '{
		link_filter_code:    `DLM_FILT_NONE,
		link_format_code:    `DLM_FMT_RST,
		lane_sharing:        1'b0,
		serializer_pll_code: `DLM_PLL_RST,
		chan_a_word_order:   8'h00,
		chan_b_word_order:   8'h00
	};

	always_comb begin
		st_next = st_reg;
		if (req.wr) begin
			case (req.page)
				`DLM_PG_MAIN: begin
					case (req.addr)
						`DLM_A_RESTART: begin
							if (req.data[`DLM_B_RESTART]) begin
								st_next.act = st_reg.stage;
							end
						end
						`DLM_A_FILTER: begin
							st_next.stage.filter_enable = req.data[`DLM_B_FIL_EN];
							st_next.stage.filter_response_code =
								{req.data[`DLM_B_RESP_MSB], req.data[`DLM_F_RESP_LO]};
						end
						`DLM_A_DECIM: begin
							st_next.stage.decimation_path_enable = req.data[`DLM_B_DEC_EN];
						end
						`DLM_A_ORDER_EN1: begin
							st_next.stage.word_order_enable_first = req.data[`DLM_B_ORDER_EN1];
						end
						`DLM_A_ORDER_EN2: begin
							st_next.stage.word_order_enable_second = req.data[`DLM_B_ORDER_EN2];
						end
						default: begin
						end
					endcase
				end
				`DLM_PG_LINK_DIG: begin
					case (req.addr)
						`DLM_A_LINK_FMT: begin
							st_next.link.link_filter_code = req.data[`DLM_F_LINK_FILT];
							st_next.link.link_format_code = req.data[`DLM_F_LINK_FMT];
						end
						`DLM_A_SHARING: begin
							st_next.link.lane_sharing = req.data[`DLM_B_SHARING];
						end
						`DLM_A_ORDER_A: begin
							st_next.link.chan_a_word_order = req.data;
						end
						`DLM_A_ORDER_B: begin
							st_next.link.chan_b_word_order = req.data;
						end
						default: begin
						end
					endcase
				end
				`DLM_PG_LINK_ANA: begin
					// Analog link page holds only the serializer code
					if (req.addr == `DLM_A_PLL) begin
						st_next.link.serializer_pll_code = req.data[`DLM_F_PLL];
					end
				end
				default: begin
				end
			endcase
		end
		// Each listed option is one link shape row
		st_next.act_ok = dlm_option_ok(st_reg.act, st_reg.link);
		st_next.stage_ok = dlm_option_ok(st_reg.stage, st_reg.link);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '{stage: '0, act: '0, link: LINK_RST, act_ok: 1'b1, stage_ok: 1'b1};
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Read back: staged main page, link pages; restart reads zero
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = 8'h00;
		case (req.page)
			`DLM_PG_MAIN: begin
				case (req.addr)
					`DLM_A_FILTER: begin
						// Response code straddles the enable bit
						rd_data[`DLM_B_RESP_MSB] = st_reg.stage.filter_response_code[3];
						rd_data[`DLM_B_FIL_EN] = st_reg.stage.filter_enable;
						rd_data[`DLM_F_RESP_LO] = st_reg.stage.filter_response_code[2:0];
					end
					`DLM_A_DECIM: rd_data[`DLM_B_DEC_EN] = st_reg.stage.decimation_path_enable;
					`DLM_A_ORDER_EN1: rd_data[`DLM_B_ORDER_EN1] = st_reg.stage.word_order_enable_first;
					`DLM_A_ORDER_EN2: rd_data[`DLM_B_ORDER_EN2] = st_reg.stage.word_order_enable_second;
					default: rd_data = 8'h00;
				endcase
			end
			`DLM_PG_LINK_DIG: begin
				case (req.addr)
					`DLM_A_LINK_FMT: rd_data = {2'h0, st_reg.link.link_filter_code,
						st_reg.link.link_format_code};
					`DLM_A_SHARING: rd_data[`DLM_B_SHARING] = st_reg.link.lane_sharing;
					`DLM_A_ORDER_A: rd_data = st_reg.link.chan_a_word_order;
					`DLM_A_ORDER_B: rd_data = st_reg.link.chan_b_word_order;
					default: rd_data = 8'h00;
				endcase
			end
			`DLM_PG_LINK_ANA: begin
				if (req.addr == `DLM_A_PLL) begin
					rd_data[`DLM_F_PLL] = st_reg.link.serializer_pll_code;
				end
			end
			default: rd_data = 8'h00;
		endcase
	end

	assign main_cfg = st_reg.act;
	assign link_cfg = st_reg.link;
	assign cfg_supported = st_reg.act_ok;
	assign stage_supported = st_reg.stage_ok;

endmodule

// ---- logic/dlm_serial_port.sv ----
// Serial register port: shifts 24-bit frames in on sclk rising edges.
// Assumes sclk, sdin and sen_n are synchronous to core_clk and slower than it.
`timescale 1ns/1ps
`include "dlm_map.svh"

module dlm_serial_port
	import dlm_pkg::*;
(
	input  wire logic       core_clk, // System clock
	input  wire logic       rst,      // Async reset, high
	input  wire logic       sclk,     // Serial clock
	input  wire logic       sdin,     // Serial data in
	input  wire logic       sen_n,    // Frame enable, low
	input  wire logic [7:0] rd_data,  // Read data for query
	output dlm_req_s        req,      // Write pulse and query address
	output logic            sdout     // Serial data out
);

	typedef struct packed {
		logic                   sclk_d;
		logic [`DLM_CNT_W-1:0]  cnt;
		logic [23:0]            shin;
		logic [7:0]             shout;
		logic                   sdout;
		logic                   wr;
	} dlm_sp_s;

	dlm_sp_s st_reg;
	dlm_sp_s st_next;

	always_comb begin
		st_next = st_reg;
		st_next.sclk_d = sclk;
		st_next.wr = 1'b0;
		if (sen_n) begin
			st_next.cnt = '0;
		end else if (sclk && !st_reg.sclk_d) begin
			st_next.shin = {st_reg.shin[22:0], sdin};
			if (st_reg.cnt != `DLM_CNT_W'(`DLM_FRAME_BITS)) begin
				st_next.cnt = st_reg.cnt + 1'b1;
			end
			if (st_reg.cnt == `DLM_CNT_W'(`DLM_FRAME_BITS - 1) && !st_reg.shin[22]) begin
				st_next.wr = 1'b1;
			end
		end else if (!sclk && st_reg.sclk_d) begin
			if (st_reg.cnt == `DLM_CNT_W'(`DLM_HDR_BITS)) begin
				st_next.sdout = rd_data[7];
				st_next.shout = {rd_data[6:0], 1'b0};
			end else if (st_reg.cnt > `DLM_CNT_W'(`DLM_HDR_BITS)) begin
				st_next.sdout = st_reg.shout[7];
				st_next.shout = {st_reg.shout[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Query address is header bits while reading, frame bits at write
	always_comb begin
		req.wr = st_reg.wr;
		req.data = st_reg.shin[7:0];
		if (st_reg.wr) begin
			req.page = st_reg.shin[22:20];
			req.addr = st_reg.shin[19:8];
		end else begin
			req.page = st_reg.shin[14:12];
			req.addr = st_reg.shin[11:0];
		end
	end

	assign sdout = st_reg.sdout;

endmodule
